/* File: status_report_pkg.sv */
// package: register selects, bit positions and reset values for load status reporting
`default_nettype none
package status_report_pkg;
    // register select codes on the host access port
    localparam logic [2:0] SEL_QUESTIONABLE_SUMMARY_COND = 3'h0;
    localparam logic [2:0] SEL_QUESTIONABLE_SUMMARY_EVENT = 3'h1;
    localparam logic [2:0] SEL_QUESTIONABLE_SUMMARY_ENABLE = 3'h2;
    localparam logic [2:0] SEL_OPERATION_SUMMARY_COND = 3'h3;
    localparam logic [2:0] SEL_OPERATION_SUMMARY_EVENT = 3'h4;
    localparam logic [2:0] SEL_OPERATION_SUMMARY_ENABLE = 3'h5;
    // questionable bit positions
    localparam int QB_FREQ_LO = 0;
    localparam int QB_FREQ_HI = 1;
    localparam int QB_UNDERVOLT = 2;
    localparam int QB_OVERVOLT = 3;
    localparam int QB_OVERCURR = 5;
    localparam int QB_OVERPOW = 7;
    // operation bit positions
    localparam int OB_LOAD_FAIL = 0;
    localparam int OB_OVERTEMP = 1;
    localparam int OB_FAN_FAIL = 2;
    // status byte summary positions
    localparam int STB_QUESTIONABLE_SUMMARY_BIT = 3;
    localparam int STB_OPERATION_SUMMARY_BIT = 7;
    // implemented bits; the rest read as zero in condition and event registers
    localparam logic [7:0] QUESTIONABLE_SUMMARY_MASK = 8'hAF;
    localparam logic [7:0] OPERATION_SUMMARY_MASK = 8'h07;
    localparam logic [7:0] REG_RESET = 8'h00;
endpackage
`default_nettype wire

/* File: load_status_reporting.sv */
// module: condition, event and enable registers with status byte summaries
`timescale 1ns/1ps
`default_nettype none
// Function
// - condition register shows live state; reads harmless
// - only monitored conditions change condition registers
// - enable masks select events for summary
// - questionable condition set means fault true
// - questionable event read returns then clears
// - enabled questionable events drive status bit 3
// - operation condition set means fault true
// - operation event read returns then clears
// - enabled operation events drive status bit 7
// - questionable bits 0,1 flag frequency fault
// - questionable bit 2 flags undervoltage
// - questionable bit 3 flags overvoltage
// - questionable bit 5 flags overcurrent
// - questionable bit 7 flags overpower
// - operation bits: load fail, overtemp, fan
// - event registers read-only, hold all events
// - enables read/write; operation summary ORs enabled
module load_status_reporting
    import status_report_pkg::*;
#(
    parameter int REG_W = 8,
    parameter int SYNC_STAGES = 2
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic freq_low_fault,
    input wire logic freq_high_fault,
    input wire logic undervoltage_flag,
    input wire logic overvoltage_flag,
    input wire logic overcurrent_flag,
    input wire logic overpower_flag,
    input wire logic load_failure_flag,
    input wire logic overtemp_flag,
    input wire logic fan_failure_flag,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [2:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic questionable_summary,
    output logic operation_summary
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] q_sync1;
        logic [7:0] q_sync2;
        logic [7:0] o_sync1;
        logic [7:0] o_sync2;
        logic [7:0] q_cond;
        logic [7:0] q_event;
        logic [7:0] q_enable;
        logic [7:0] o_cond;
        logic [7:0] o_event;
        logic [7:0] o_enable;
        logic [7:0] rdata;
        logic rvalid;
        logic q_sum;
        logic o_sum;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic [7:0] q_pins;
    logic [7:0] o_pins;
    logic q_event_rd;
    logic o_event_rd;
    logic q_enable_wr;
    logic o_enable_wr;

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // the masks and data ports are eight bits wide; the selects are three bits
    if (REG_W != 8) begin : g_width_check
        $error("load_status_reporting: REG_W must be 8");
    end
    // condition timing and its checks assume exactly two sync flops
    if (SYNC_STAGES != 2) begin : g_sync_check
        $error("load_status_reporting: SYNC_STAGES must be 2");
    end

    // ----------------------------------------
    // fault inputs mapped onto register bits
    // ----------------------------------------
    always_comb begin
        q_pins = 8'h00;
        q_pins[QB_FREQ_LO] = freq_low_fault;
        q_pins[QB_FREQ_HI] = freq_high_fault;
        q_pins[QB_UNDERVOLT] = undervoltage_flag;
        q_pins[QB_OVERVOLT] = overvoltage_flag;
        q_pins[QB_OVERCURR] = overcurrent_flag;
        q_pins[QB_OVERPOW] = overpower_flag;
        o_pins = 8'h00;
        o_pins[OB_LOAD_FAIL] = load_failure_flag;
        o_pins[OB_OVERTEMP] = overtemp_flag;
        o_pins[OB_FAN_FAIL] = fan_failure_flag;
    end

    function automatic logic [7:0] read_mux(input state_s s, input logic [2:0] sel);
        case (sel)
            SEL_QUESTIONABLE_SUMMARY_COND: read_mux = s.q_cond;
            SEL_QUESTIONABLE_SUMMARY_EVENT: read_mux = s.q_event;
            SEL_QUESTIONABLE_SUMMARY_ENABLE: read_mux = s.q_enable;
            SEL_OPERATION_SUMMARY_COND: read_mux = s.o_cond;
            SEL_OPERATION_SUMMARY_EVENT: read_mux = s.o_event;
            SEL_OPERATION_SUMMARY_ENABLE: read_mux = s.o_enable;
            default: read_mux = 8'h00;
        endcase
    endfunction

    // one decoder for host strobes, shared by the update logic and the checks
    function automatic logic hits(input logic strobe, input logic [2:0] sel, input logic [2:0] code);
        hits = strobe && (sel == code);
    endfunction

    assign q_event_rd = hits(reg_rd, reg_sel, SEL_QUESTIONABLE_SUMMARY_EVENT);
    assign o_event_rd = hits(reg_rd, reg_sel, SEL_OPERATION_SUMMARY_EVENT);
    assign q_enable_wr = hits(reg_wr, reg_sel, SEL_QUESTIONABLE_SUMMARY_ENABLE);
    assign o_enable_wr = hits(reg_wr, reg_sel, SEL_OPERATION_SUMMARY_ENABLE);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [7:0] q_rise;
        logic [7:0] o_rise;
        q_rise = 8'h00;
        o_rise = 8'h00;
        st_nxt = st_r;
        // pins are asynchronous to clk_sys: two flops before use
        st_nxt.q_sync1 = q_pins;
        st_nxt.q_sync2 = st_r.q_sync1;
        st_nxt.o_sync1 = o_pins;
        st_nxt.o_sync2 = st_r.o_sync1;
        // live condition, never touched by host access
        st_nxt.q_cond = st_r.q_sync2 & QUESTIONABLE_SUMMARY_MASK;
        st_nxt.o_cond = st_r.o_sync2 & OPERATION_SUMMARY_MASK;
        q_rise = st_nxt.q_cond & ~st_r.q_cond;
        o_rise = st_nxt.o_cond & ~st_r.o_cond;
        st_nxt.rvalid = reg_rd;
        st_nxt.rdata = reg_rd ? read_mux(st_r, reg_sel) : 8'h00;
        // read clears, but a rising edge in the same cycle survives
        if (q_event_rd) begin
            st_nxt.q_event = q_rise;
        end else begin
            st_nxt.q_event = st_r.q_event | q_rise;
        end
        if (o_event_rd) begin
            st_nxt.o_event = o_rise;
        end else begin
            st_nxt.o_event = st_r.o_event | o_rise;
        end
        // event registers ignore writes; only enables are writable
        if (q_enable_wr) begin
            st_nxt.q_enable = reg_wdata;
        end
        if (o_enable_wr) begin
            st_nxt.o_enable = reg_wdata;
        end
        st_nxt.q_sum = |(st_nxt.q_event & st_nxt.q_enable);
        st_nxt.o_sum = |(st_nxt.o_event & st_nxt.o_enable);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign questionable_summary = st_r.q_sum;
    assign operation_summary = st_r.o_sum;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // condition checks
    // ----------------------------------------
    cond_follows_a: assert property (clk_en ##1 clk_en |->
        st_r.q_cond == ($past(st_r.q_sync2) & QUESTIONABLE_SUMMARY_MASK))
        else $error("questionable condition does not track pins");

    operation_summary_follows_a: assert property (clk_en |=>
        st_r.o_cond == ($past(st_r.o_sync2) & OPERATION_SUMMARY_MASK))
        else $error("operation condition does not track pins");

    cond_no_host_a: assert property (clk_en && (reg_rd || reg_wr) |=>
        st_r.o_cond == ($past(st_r.o_sync2) & OPERATION_SUMMARY_MASK))
        else $error("operation condition changed by host");

    cond_read_a: assert property (clk_en && hits(reg_rd, reg_sel, SEL_QUESTIONABLE_SUMMARY_COND) |=>
        reg_rdata == $past(st_r.q_cond))
        else $error("condition read returned wrong value");

    questionable_summary_map_a: assert property (clk_en |=>
        st_r.q_sync1 == {$past(overpower_flag), 1'h0, $past(overcurrent_flag), 1'h0,
        $past(overvoltage_flag), $past(undervoltage_flag), $past(freq_high_fault), $past(freq_low_fault)})
        else $error("questionable fault pin on wrong bit");

    operation_summary_map_a: assert property (clk_en |=>
        st_r.o_sync1 == {5'h00, $past(fan_failure_flag), $past(overtemp_flag), $past(load_failure_flag)})
        else $error("operation fault pin on wrong bit");

    cond_unused_a: assert property ((st_r.q_cond & ~QUESTIONABLE_SUMMARY_MASK) == 8'h00 &&
        (st_r.o_cond & ~OPERATION_SUMMARY_MASK) == 8'h00)
        else $error("unassigned condition bit set");

    // ----------------------------------------
    // event checks
    // ----------------------------------------
    questionable_summary_clear_a: assert property (clk_en && q_event_rd |=>
        st_r.q_event == (st_r.q_cond & ~$past(st_r.q_cond)))
        else $error("questionable event not cleared on read");

    operation_summary_clear_a: assert property (clk_en && o_event_rd |=>
        st_r.o_event == (st_r.o_cond & ~$past(st_r.o_cond)))
        else $error("operation event not cleared on read");

    questionable_summary_read_a: assert property (clk_en && q_event_rd |=>
        reg_rvalid && reg_rdata == $past(st_r.q_event))
        else $error("questionable event read lost its contents");

    operation_summary_read_a: assert property (clk_en && o_event_rd |=>
        reg_rvalid && reg_rdata == $past(st_r.o_event))
        else $error("operation event read lost its contents");

    event_hold_a: assert property (clk_en && !q_event_rd |=>
        (st_r.q_event & $past(st_r.q_event)) == $past(st_r.q_event))
        else $error("questionable event bit lost");

    operation_summary_hold_a: assert property (clk_en && !o_event_rd |=>
        (st_r.o_event & $past(st_r.o_event)) == $past(st_r.o_event))
        else $error("operation event bit lost");

    questionable_summary_set_a: assert property (clk_en |=>
        ((st_r.q_cond & ~$past(st_r.q_cond)) & ~st_r.q_event) == 8'h00)
        else $error("questionable rise not latched");

    operation_summary_set_a: assert property (clk_en |=>
        ((st_r.o_cond & ~$past(st_r.o_cond)) & ~st_r.o_event) == 8'h00)
        else $error("operation rise not latched");

    event_ro_a: assert property (clk_en && !reg_rd && reg_wr && reg_sel == SEL_QUESTIONABLE_SUMMARY_EVENT |=>
        st_r.q_event == ($past(st_r.q_event) | (st_r.q_cond & ~$past(st_r.q_cond))))
        else $error("host write altered questionable event");

    unused_zero_a: assert property ((st_r.q_event & ~QUESTIONABLE_SUMMARY_MASK) == 8'h00 &&
        (st_r.o_event & ~OPERATION_SUMMARY_MASK) == 8'h00)
        else $error("unassigned event bit set");

    // ----------------------------------------
    // host access, summary and clock enable checks
    // ----------------------------------------
    read_data_a: assert property (clk_en && hits(reg_rd, reg_sel, SEL_QUESTIONABLE_SUMMARY_ENABLE) |=>
        reg_rvalid && reg_rdata == $past(st_r.q_enable))
        else $error("enable readback wrong");

    enable_write_a: assert property (clk_en && q_enable_wr |=>
        st_r.q_enable == $past(reg_wdata))
        else $error("questionable enable write lost");

    operation_summary_write_a: assert property (clk_en && o_enable_wr |=>
        st_r.o_enable == $past(reg_wdata))
        else $error("operation enable write lost");

    unused_sel_a: assert property (clk_en && reg_rd && reg_sel > SEL_OPERATION_SUMMARY_ENABLE |=>
        reg_rdata == 8'h00)
        else $error("unassigned select returned data");

    questionable_summary_sum_a: assert property (questionable_summary == |(st_r.q_event & st_r.q_enable))
        else $error("questionable summary mismatch");

    operation_summary_sum_a: assert property (operation_summary == |(st_r.o_event & st_r.o_enable))
        else $error("operation summary mismatch");

    freeze_a: assert property (!clk_en |=> $stable(st_r))
        else $error("state moved while clock enable low");

    // ----------------------------------------
    // coverage
    // ----------------------------------------
    questionable_summary_event_c: cover property (st_r.q_event != 8'h00 ##[1:20] q_event_rd);
    operation_summary_sum_c: cover property (operation_summary);
    questionable_summary_sum_c: cover property (questionable_summary);
    freeze_c: cover property (!clk_en ##1 clk_en);
    operation_summary_read_c: cover property (clk_en && o_event_rd && st_r.o_event != 8'h00);
endmodule
`default_nettype wire

/* File: test_load_status_reporting.sv */
// testbench: fault pins and host register accesses of the load status reporting block
`timescale 1ns/1ps
`default_nettype none
module test_load_status_reporting;
    import status_report_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic [8:0] pins = 9'h000;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [2:0] reg_sel = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic questionable_summary;
    logic operation_summary;
    int miscompares = 0;
    int check_count = 0;
    int pos[9] = '{QB_FREQ_LO, QB_FREQ_HI, QB_UNDERVOLT, QB_OVERVOLT, QB_OVERCURR, QB_OVERPOW,
                   OB_LOAD_FAIL, OB_OVERTEMP, OB_FAN_FAIL};
    load_status_reporting i_dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .freq_low_fault(pins[0]), .freq_high_fault(pins[1]), .undervoltage_flag(pins[2]),
        .overvoltage_flag(pins[3]), .overcurrent_flag(pins[4]), .overpower_flag(pins[5]),
        .load_failure_flag(pins[6]), .overtemp_flag(pins[7]), .fan_failure_flag(pins[8]),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .questionable_summary(questionable_summary), .operation_summary(operation_summary));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // read data is only valid in the one cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [2:0] sel, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_sel <= sel;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("read valid", 8'h01, {7'h00, reg_rvalid});
        chk(what, exp, reg_rdata);
    endtask
    task automatic wr(input logic [2:0] sel, input logic [7:0] data);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_sel <= sel;
        reg_wdata <= data;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic summ(input logic [1:0] exp);
        tick(2);
        #1;
        chk("summaries", {6'h00, exp}, {6'h00, operation_summary, questionable_summary});
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int s = 0; s < 8; s++) rd(3'(s), REG_RESET, "reset value");
        // one pin at a time pins down each bit position; pins go through a 3-cycle sync path
        for (int i = 0; i < 9; i++) begin
            pins <= 9'h001 << i;
            tick(5);
            rd((i < 6) ? SEL_QUESTIONABLE_SUMMARY_COND : SEL_OPERATION_SUMMARY_COND, 8'h01 << pos[i], "condition");
            rd((i < 6) ? SEL_QUESTIONABLE_SUMMARY_EVENT : SEL_OPERATION_SUMMARY_EVENT, 8'h01 << pos[i], "event");
            rd((i < 6) ? SEL_QUESTIONABLE_SUMMARY_EVENT : SEL_OPERATION_SUMMARY_EVENT, 8'h00, "event cleared");
            tick(1);
            pins <= 9'h000;
            tick(5);
        end
        pins <= 9'h1FF;
        tick(5);
        rd(SEL_QUESTIONABLE_SUMMARY_COND, QUESTIONABLE_SUMMARY_MASK, "questionable_summary condition");
        rd(SEL_QUESTIONABLE_SUMMARY_COND, QUESTIONABLE_SUMMARY_MASK, "questionable_summary condition reread");
        wr(SEL_QUESTIONABLE_SUMMARY_COND, 8'h00);
        wr(SEL_QUESTIONABLE_SUMMARY_EVENT, 8'h00);
        rd(SEL_QUESTIONABLE_SUMMARY_COND, QUESTIONABLE_SUMMARY_MASK, "questionable_summary condition after write");
        summ(2'b00);
        wr(SEL_QUESTIONABLE_SUMMARY_ENABLE, 8'h80);
        summ(2'b01);
        wr(SEL_QUESTIONABLE_SUMMARY_ENABLE, 8'h50);
        summ(2'b00);
        rd(SEL_QUESTIONABLE_SUMMARY_ENABLE, 8'h50, "questionable_summary enable");
        wr(SEL_OPERATION_SUMMARY_ENABLE, 8'h04);
        summ(2'b10);
        rd(SEL_OPERATION_SUMMARY_ENABLE, 8'h04, "operation_summary enable");
        rd(SEL_QUESTIONABLE_SUMMARY_EVENT, QUESTIONABLE_SUMMARY_MASK, "questionable_summary event held");
        rd(SEL_OPERATION_SUMMARY_EVENT, OPERATION_SUMMARY_MASK, "operation_summary event held");
        summ(2'b00);
        rd(SEL_OPERATION_SUMMARY_COND, OPERATION_SUMMARY_MASK, "operation_summary condition after read");
        // a pulse that comes and goes while the enable is low must leave no event
        tick(1);
        pins <= 9'h000;
        tick(5);
        clk_en <= 1'b0;
        pins <= 9'h001;
        tick(6);
        pins <= 9'h000;
        clk_en <= 1'b1;
        tick(5);
        rd(SEL_QUESTIONABLE_SUMMARY_EVENT, 8'h00, "event after frozen pulse");
        // mid-run reset must clear the enables written above
        tick(1);
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        rd(SEL_QUESTIONABLE_SUMMARY_ENABLE, REG_RESET, "questionable_summary enable after reset");
        rd(SEL_OPERATION_SUMMARY_ENABLE, REG_RESET, "operation_summary enable after reset");
        summ(2'b00);
        end_sim();
    end
endmodule
`default_nettype wire
